/* File: shared/fsp_pkg.sv */
/*
 Shared constants for the flash self-programming sequencer:
 register offsets, control field positions, legal command codes.
 Assumes an 8-bit register port with a 4-bit address.
*/
package fsp_pkg;
    // Register port geometry
    localparam int         REG_ADDR_W  = 4;
    localparam int         REG_DATA_W  = 8;
    localparam logic [3:0] REG_CTRL    = 4'h0;  // store_program_control
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] READ_ZERO   = 8'h00;

    // Control field positions
    localparam int STORE_ENABLE_BIT = 0;
    localparam int PAGE_ERASE_BIT   = 1;
    localparam int PAGE_PROGRAM_BIT = 2;
    localparam int LOCK_SET_BIT     = 3;
    localparam int REENABLE_BIT     = 4;
    localparam int SECTION_BUSY_BIT = 6;
    localparam int CMD_W            = 5;

    // The only accepted low-five-bit patterns
    localparam logic [4:0] CODE_REENABLE = 5'h11;  // 10001
    localparam logic [4:0] CODE_LOCK     = 5'h09;  // 01001
    localparam logic [4:0] CODE_PROGRAM  = 5'h05;  // 00101
    localparam logic [4:0] CODE_ERASE    = 5'h03;  // 00011
    localparam logic [4:0] CODE_LOAD     = 5'h01;  // 00001
    localparam logic [4:0] CMD_NONE      = 5'h00;

    // Arming window length in clock cycles
    localparam logic [2:0] ARM_CYCLES    = 3'h4;
    localparam int         ARM_W         = 3;

    // Pointer and data widths
    localparam int PTR_W       = 16;
    localparam int WORD_W      = 16;
    localparam int LOCK_W      = 8;
endpackage

/* File: src/fsp_arm_window.sv */
/*
 Four-cycle arming window for the store-program instruction.
 Assumes arm and stop are single-cycle pulses from the sequencer.
*/
`timescale 1ns/1ns
module fsp_arm_window #(
    parameter logic [fsp_pkg::ARM_W-1:0] CYCLES = fsp_pkg::ARM_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic arm,
    input  wire logic stop,
    output logic      armed,
    output logic      expire
);
    import fsp_pkg::*;

    logic [ARM_W-1:0] cnt;
    logic [ARM_W-1:0] next_cnt;

    // Rearming restarts the full window
    always_comb begin
        next_cnt = cnt;
        if (arm) begin
            next_cnt = CYCLES;
        end else if (stop) begin
            next_cnt = '0;
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt <= '0;
        end else if (clk_en) begin
            cnt <= next_cnt;
        end
    end

    // Last armed cycle with nothing taken
    assign armed  = (cnt != '0);
    assign expire = clk_en && (cnt == 1) && !arm && !stop;
endmodule

/* File: src/fsp_page_buffer.sv */
/*
 Temporary page buffer held in flip-flops, one word per index.
 Assumes the flash array reads it through the registered port.
*/
`timescale 1ns/1ns
module fsp_page_buffer #(
    parameter int WORDS = 64,
    parameter int WIDTH = 16,
    parameter int IDX_W = $clog2(WORDS)
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic             wr,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             clear,
    input  wire logic [IDX_W-1:0] rd_idx,
    output logic      [WIDTH-1:0] rd_data,
    output logic                  loaded
);
    logic [WIDTH-1:0] mem      [WORDS];
    logic [WIDTH-1:0] next_mem [WORDS];
    logic             next_loaded;

    // Clear beats a write; erased words read all ones
    always_comb begin
        next_mem    = mem;
        next_loaded = loaded;
        if (clear) begin
            for (int i = 0; i < WORDS; i++) begin
                next_mem[i] = '1;
            end
            next_loaded = 1'b0;
        end else if (wr) begin
            next_mem[wr_idx] = wr_data;
            next_loaded      = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < WORDS; i++) begin
                mem[i] <= '1;
            end
            loaded  <= 1'b0;
            rd_data <= '1;
        end else if (clk_en) begin
            mem     <= next_mem;
            loaded  <= next_loaded;
            rd_data <= mem[rd_idx];
        end
    end
endmodule

/* File: src/fsp_sequencer.sv */
/*
 Flash self-programming sequencer: control register, arming window,
 buffer loads, page erase, page write, lock set, section re-enable.
 Assumes the CPU pulses store_program_instr once per store-program
 instruction and the flash array answers each start with flash_done.
*/
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ns
module fsp_sequencer #(
    parameter int PAGE_WORDS      = 64,
    parameter int HALT_FIRST_PAGE = 112
) (
    input  wire logic                             sys_clk,
    input  wire logic                             reset,
    input  wire logic                             clk_en,
    input  wire logic [fsp_pkg::REG_ADDR_W-1:0]   reg_addr,
    input  wire logic [fsp_pkg::REG_DATA_W-1:0]   reg_wdata,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    output logic      [fsp_pkg::REG_DATA_W-1:0]   reg_rdata,
    input  wire logic                             store_program_instr,
    input  wire logic [fsp_pkg::PTR_W-1:0]        pointer,
    input  wire logic [fsp_pkg::WORD_W-1:0]       data_register_pair,
    input  wire logic                             eeprom_write,
    output logic                                  flash_op_start,
    output logic                                  flash_op_erase,
    output logic [fsp_pkg::PTR_W-2-$clog2(PAGE_WORDS):0] flash_page,
    input  wire logic                             flash_done,
    input  wire logic [$clog2(PAGE_WORDS)-1:0]    flash_buf_idx,
    output logic      [fsp_pkg::WORD_W-1:0]       flash_buf_data,
    output logic                                  lock_write,
    output logic      [fsp_pkg::LOCK_W-1:0]       lock_data,
    output logic                                  cpu_halt,
    output logic                                  section_busy
);
    import fsp_pkg::*;

    localparam int WORD_BITS = $clog2(PAGE_WORDS);
    localparam int PAGE_BITS = PTR_W - 1 - WORD_BITS;

    typedef enum logic [1:0] {FSP_IDLE, FSP_ARMED, FSP_BUSY} fsp_state_e;

    // Accepts only the five documented low patterns
    function automatic logic legal_code(input logic [CMD_W-1:0] c);
        return (c == CODE_REENABLE) || (c == CODE_LOCK) ||
               (c == CODE_PROGRAM) || (c == CODE_ERASE) ||
               (c == CODE_LOAD);
    endfunction

    // Page part of the pointer; bit 0 picks a byte and is dropped
    function automatic logic [PAGE_BITS-1:0] page_of(input logic [PTR_W-1:0] p);
        return p[PTR_W-1 -: PAGE_BITS];
    endfunction

    fsp_state_e           state;
    fsp_state_e           next_state;
    logic [CMD_W-1:0]     cmd;
    logic [CMD_W-1:0]     next_cmd;
    logic                 next_section_busy;
    logic                 op_halting;
    logic                 next_op_halting;
    logic [PAGE_BITS-1:0] next_flash_page;
    logic                 next_flash_op_start;
    logic                 next_flash_op_erase;
    logic                 next_cpu_halt;
    logic                 next_lock_write;
    logic [LOCK_W-1:0]    next_lock_data;
    logic [REG_DATA_W-1:0] next_reg_rdata;

    logic                 wr_ctrl;
    logic                 write_ok;
    logic                 instr_take;
    logic                 arm;
    logic                 stop;
    logic                 armed;
    logic                 expire;
    logic                 buf_wr;
    logic                 buf_clear;
    logic                 buf_loaded;
    logic [WORD_BITS-1:0] word_idx;
    logic                 target_halting;

    // Word index sits just above the byte bit
    assign word_idx    = pointer[WORD_BITS:1];
    assign target_halting = (page_of(pointer) >= PAGE_BITS'(HALT_FIRST_PAGE));

    // Register access decode; writes refused during an operation
    assign wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
    assign write_ok = wr_ctrl && (state != FSP_BUSY)
                      && legal_code(reg_wdata[CMD_W-1:0]);
    assign instr_take = store_program_instr && armed
                      && (state == FSP_ARMED);

    fsp_arm_window #(
        .CYCLES (ARM_CYCLES)
    ) u_window (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .arm     (arm),
        .stop    (stop),
        .armed   (armed),
        .expire  (expire)
    );

    fsp_page_buffer #(
        .WORDS (PAGE_WORDS),
        .WIDTH (WORD_W)
    ) u_buffer (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .wr      (buf_wr),
        .wr_idx  (word_idx),
        .wr_data (data_register_pair),
        .clear   (buf_clear),
        .rd_idx  (flash_buf_idx),
        .rd_data (flash_buf_data),
        .loaded  (buf_loaded)
    );

    // Sequencer next state; a taken instruction beats a rewrite
    always_comb begin
        next_state          = state;
        next_cmd            = cmd;
        next_section_busy   = section_busy;
        next_op_halting     = op_halting;
        next_flash_page     = flash_page;
        next_flash_op_erase = flash_op_erase;
        next_flash_op_start = 1'b0;
        next_cpu_halt       = cpu_halt;
        next_lock_write     = 1'b0;
        next_lock_data      = lock_data;
        arm                 = 1'b0;
        stop                = 1'b0;
        buf_wr              = 1'b0;
        buf_clear           = 1'b0;
        case (state)
            FSP_IDLE, FSP_ARMED: begin
                if (instr_take) begin
                    stop     = 1'b1;
                    next_cmd = CMD_NONE;
                    next_state = FSP_IDLE;
                    case (cmd)
                        CODE_LOAD: begin
                            buf_wr            = 1'b1;
                            next_section_busy = 1'b0;
                        end
                        CODE_ERASE, CODE_PROGRAM: begin
                            // Latch now so the pointer is free again
                            next_flash_page     = page_of(pointer);
                            next_flash_op_erase = (cmd == CODE_ERASE);
                            next_flash_op_start = 1'b1;
                            next_op_halting     = target_halting;
                            next_cpu_halt       = target_halting;
                            next_section_busy   = section_busy || !target_halting;
                            next_cmd            = cmd;
                            next_state          = FSP_BUSY;
                        end
                        CODE_REENABLE: begin
                            next_section_busy = 1'b0;
                        end
                        CODE_LOCK: begin
                            // Pointer plays no part here
                            next_lock_write = 1'b1;
                            next_lock_data  = data_register_pair[LOCK_W-1:0];
                        end
                        default: begin
                            next_state = FSP_IDLE;
                        end
                    endcase
                end else if (write_ok) begin
                    arm        = 1'b1;
                    next_cmd   = reg_wdata[CMD_W-1:0];
                    next_state = FSP_ARMED;
                    if (reg_wdata[REENABLE_BIT]) begin
                        buf_clear = 1'b1;
                    end
                end else if (expire) begin
                    next_cmd   = CMD_NONE;
                    next_state = FSP_IDLE;
                end
            end
            FSP_BUSY: begin
                if (flash_done) begin
                    next_cmd      = CMD_NONE;
                    next_cpu_halt = 1'b0;
                    next_state    = FSP_IDLE;
                    if (!flash_op_erase) begin
                        buf_clear = 1'b1;
                    end
                end
            end
            default: begin
                next_state = FSP_IDLE;
            end
        endcase
        // Half-loaded page is useless after an EEPROM write
        if (eeprom_write && buf_loaded) begin
            buf_clear = 1'b1;
        end
    end

    // Read data for the cycle after the strobe
    always_comb begin
        next_reg_rdata = READ_ZERO;
        if (reg_rd && (reg_addr == REG_CTRL)) begin
            next_reg_rdata = {1'b0, section_busy, 1'b0, cmd};
        end
    end

    // Control state; everything idle after reset
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state          <= FSP_IDLE;
            cmd            <= CTRL_RESET[CMD_W-1:0];
            section_busy   <= CTRL_RESET[SECTION_BUSY_BIT];
            op_halting     <= 1'b0;
            flash_page     <= '0;
            flash_op_start <= 1'b0;
            flash_op_erase <= 1'b0;
            cpu_halt       <= 1'b0;
            lock_write     <= 1'b0;
            lock_data      <= '0;
            reg_rdata      <= READ_ZERO;
        end else if (clk_en) begin
            state          <= next_state;
            cmd            <= next_cmd;
            section_busy   <= next_section_busy;
            op_halting     <= next_op_halting;
            flash_page     <= next_flash_page;
            flash_op_start <= next_flash_op_start;
            flash_op_erase <= next_flash_op_erase;
            cpu_halt       <= next_cpu_halt;
            lock_write     <= next_lock_write;
            lock_data      <= next_lock_data;
            reg_rdata      <= next_reg_rdata;
        end
    end

    // Helper: enabled cycles spent armed, for the window check
    logic [ARM_W:0] armed_age;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            armed_age <= '0;
        end else if (clk_en) begin
            armed_age <= (next_state == FSP_ARMED && (arm || state == FSP_ARMED))
                         ? (arm ? (ARM_W+1)'(1) : armed_age + 1'b1) : '0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_window_length: assert property (
        armed_age <= (ARM_W+1)'(ARM_CYCLES))
        else $error("arming window exceeded four cycles");

    chk_erase_start: assert property (
        clk_en && instr_take && cmd == CODE_ERASE
        |=> flash_op_start && flash_op_erase
            && flash_page == $past(page_of(pointer)))
        else $error("erase did not start on the pointer page");

    chk_program_start: assert property (
        clk_en && instr_take && cmd == CODE_PROGRAM
        |=> flash_op_start && !flash_op_erase && state == FSP_BUSY)
        else $error("page program did not start");

    chk_halt_busy: assert property (
        state == FSP_BUSY && op_halting |-> cpu_halt)
        else $error("CPU not halted during halting section operation");

    chk_enable_busy: assert property (
        state == FSP_BUSY |-> cmd[STORE_ENABLE_BIT])
        else $error("store enable dropped while busy");

    chk_done_clears: assert property (
        clk_en && state == FSP_BUSY && flash_done
        |=> cmd == CMD_NONE && !cpu_halt ##1 !flash_op_start)
        else $error("command bits not cleared at completion");

    chk_illegal_ignored: assert property (
        clk_en && wr_ctrl && state == FSP_IDLE
        && !legal_code(reg_wdata[CMD_W-1:0]) && !eeprom_write
        |=> state == FSP_IDLE && cmd == CMD_NONE)
        else $error("illegal pattern changed the command");

    chk_page_held: assert property (
        state == FSP_BUSY && $past(state) == FSP_BUSY |-> $stable(flash_page))
        else $error("latched page moved during operation");

    chk_concurrent_run: assert property (
        state == FSP_BUSY && !op_halting |-> section_busy && !cpu_halt)
        else $error("concurrent section handling wrong");

    chk_idle_clear: assert property (
        state == FSP_IDLE |-> cmd == CMD_NONE)
        else $error("command bits set while idle");

    chk_lock_data: assert property (
        clk_en && instr_take && cmd == CODE_LOCK
        |=> lock_write && lock_data == $past(data_register_pair[LOCK_W-1:0]))
        else $error("lock set did not use the low data byte");

    // A rewrite while busy would restart the window mid-operation
    chk_busy_refuse: assert property (
        clk_en && wr_ctrl && state == FSP_BUSY && !flash_done
        |=> state == FSP_BUSY && $stable(cmd))
        else $error("control write accepted while busy");

    chk_section_set: assert property (
        clk_en && instr_take && !target_halting
        && (cmd == CODE_ERASE || cmd == CODE_PROGRAM)
        |=> section_busy && !cpu_halt)
        else $error("concurrent section not marked busy");

    cov_load: cover property (clk_en && instr_take && cmd == CODE_LOAD);
    cov_reenable: cover property (clk_en && instr_take && cmd == CODE_REENABLE);
    cov_erase_done: cover property (state == FSP_BUSY && flash_op_erase && flash_done);
    cov_program_halt: cover property (state == FSP_BUSY && cpu_halt && flash_done);
    cov_timeout: cover property (expire && state == FSP_ARMED);
endmodule

/* File: verif/fsp_flash_model.sv */
/*
 Flash array model: answers each erase or program start with a done
 pulse after DELAY cycles and records what the sequencer asked for.
 Assumes one sequencer on the same clock and reset.
*/
`timescale 1ns/1ns
module fsp_flash_model #(
    parameter int PW    = 9,
    parameter int DELAY = 12
) (
    input  wire logic          sys_clk,
    input  wire logic          reset,
    input  wire logic          flash_op_start,
    input  wire logic          flash_op_erase,
    input  wire logic [PW-1:0] flash_page,
    input  wire logic          cpu_halt,
    input  wire logic          section_busy,
    input  wire logic          lock_write,
    input  wire logic [7:0]    lock_data,
    output logic               flash_done
);
    int            cnt, n_ops, n_locks;
    logic          busy, last_erase, last_halt, last_busy, hold_bad;
    logic [PW-1:0] last_page;
    logic [7:0]    last_lock;

    // Slow answer on purpose, so a stall that drops early is seen
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            flash_done <= 1'b0;
            busy <= 1'b0;
            cnt <= 0;
            n_ops <= 0;
            n_locks <= 0;
            hold_bad <= 1'b0;
            last_erase <= 1'b0;
            last_halt <= 1'b0;
            last_busy <= 1'b0;
            last_page <= '0;
            last_lock <= 8'h00;
        end else begin
            flash_done <= 1'b0;
            if (flash_op_start && !busy) begin
                busy <= 1'b1;
                cnt <= DELAY;
                last_page <= flash_page;
                last_erase <= flash_op_erase;
                last_halt <= cpu_halt;
                last_busy <= section_busy;
            end else if (busy) begin
                // Stall level must hold for the whole operation
                if (cpu_halt !== last_halt) begin
                    hold_bad <= 1'b1;
                end
                cnt <= cnt - 1;
                if (cnt == 1) begin
                    busy <= 1'b0;
                    flash_done <= 1'b1;
                    n_ops <= n_ops + 1;
                end
            end
            if (lock_write) begin
                n_locks <= n_locks + 1;
                last_lock <= lock_data;
            end
        end
    end
endmodule

/* File: verif/tb_top.sv */
/*
 Self-checking bench for the flash self-programming sequencer.
 Assumes fsp_pkg and the flash array model fsp_flash_model.
*/
`timescale 1ns/1ns
module tb_top;
    import fsp_pkg::*;
    logic        sys_clk, reset, reg_wr, reg_rd, store_program_instr, eeprom_write;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, lock_data;
    logic [15:0] pointer, data_register_pair, flash_buf_data;
    logic [8:0]  flash_page;
    logic [5:0]  flash_buf_idx;
    logic        flash_op_start, flash_op_erase, flash_done, lock_write, cpu_halt, section_busy;
    int          err_total, compares;
    int          cycles = 0;

    fsp_sequencer dut_u (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .store_program_instr(store_program_instr), .pointer(pointer),
        .data_register_pair(data_register_pair), .eeprom_write(eeprom_write),
        .flash_op_start(flash_op_start), .flash_op_erase(flash_op_erase), .flash_page(flash_page),
        .flash_done(flash_done), .flash_buf_idx(flash_buf_idx), .flash_buf_data(flash_buf_data),
        .lock_write(lock_write), .lock_data(lock_data), .cpu_halt(cpu_halt), .section_busy(section_busy));

    fsp_flash_model #(.PW(9), .DELAY(12)) m_u (.sys_clk(sys_clk), .reset(reset),
        .flash_op_start(flash_op_start), .flash_op_erase(flash_op_erase), .flash_page(flash_page),
        .cpu_halt(cpu_halt), .section_busy(section_busy), .lock_write(lock_write),
        .lock_data(lock_data), .flash_done(flash_done));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= REG_CTRL;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", exp, reg_rdata);
    endtask

    task automatic store_instr();
        store_program_instr <= 1'b1;
        @(posedge sys_clk);
        store_program_instr <= 1'b0;
    endtask

    task automatic chk_buf(input logic [5:0] i, input logic [15:0] exp);
        @(posedge sys_clk);
        flash_buf_idx <= i;
        repeat (2) @(posedge sys_clk);
        #1 chk("flash_buf_data", exp, flash_buf_data);
    endtask

    // Odd page bits and a set low bit must not matter to a load
    task automatic load(input logic [5:0] i, input logic [15:0] d);
        pointer <= {9'h1a5, i, 1'b1};
        data_register_pair <= d;
        wr(8'h01);
        store_instr();
    endtask

    // Pointer is scrambled right after the start to expose a late latch
    task automatic do_op(input logic [7:0] code, input logic [15:0] ptr, input logic [8:0] pg,
                         input logic halt);
        int n;
        n = m_u.n_ops;
        pointer <= ptr;
        wr(code);
        store_instr();
        pointer <= 16'h0000;
        rd(REG_CTRL, {1'b0, !halt, 1'b0, code[4:0]});
        wr(8'h11);
        rd(REG_CTRL, {1'b0, !halt, 1'b0, code[4:0]});
        repeat (40) if (m_u.n_ops == n) @(posedge sys_clk);
        chk("op_count", n + 1, m_u.n_ops);
        chk("op_page", pg, m_u.last_page);
        chk("op_erase", code == 8'h03, m_u.last_erase);
        chk("op_halt", halt, m_u.last_halt);
        chk("op_busy", !halt, m_u.last_busy);
        chk("halt_hold", 1'b0, m_u.hold_bad);
        rd(REG_CTRL, {1'b0, !halt, 6'h00});
    endtask

    task automatic t_reset();
        rd(REG_CTRL, CTRL_RESET);
        rd(4'h5, READ_ZERO);
        chk("cpu_halt", 1'b0, cpu_halt);
        chk("section_busy", 1'b0, section_busy);
        chk_buf(6'd0, 16'hffff);
    endtask

    task automatic t_codes();
        logic [7:0] bad [4] = '{8'h07, 8'h1f, 8'h02, 8'h0b};
        logic [7:0] good [5] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h11};
        foreach (bad[k]) begin
            wr(bad[k]);
            rd(REG_CTRL, 8'h00);
        end
        // Armed without an instruction, each code must lapse
        foreach (good[k]) begin
            wr(good[k]);
            rd(REG_CTRL, good[k]);
            repeat (4) @(posedge sys_clk);
            rd(REG_CTRL, 8'h00);
        end
    endtask

    // Fourth armed cycle still takes the instruction, the fifth does not
    task automatic t_window();
        pointer <= 16'h0006;
        data_register_pair <= 16'h1357;
        wr(8'h01);
        repeat (3) @(posedge sys_clk);
        store_instr();
        chk_buf(6'd3, 16'h1357);
        pointer <= 16'h0008;
        data_register_pair <= 16'h2468;
        wr(8'h01);
        repeat (4) @(posedge sys_clk);
        store_instr();
        chk_buf(6'd4, 16'hffff);
    endtask

    task automatic t_erase();
        load(6'd9, 16'h1234);
        do_op(8'h03, 16'h02db, 9'd5, 1'b0);
        chk_buf(6'd9, 16'h1234);
        wr(8'h11);
        store_instr();
        chk_buf(6'd9, 16'hffff);
        chk("section_busy", 1'b0, section_busy);
        rd(REG_CTRL, 8'h00);
    endtask

    task automatic t_lock();
        int n;
        int l;
        n = m_u.n_ops;
        l = m_u.n_locks;
        data_register_pair <= 16'ha5c3;
        pointer <= 16'hffff;
        wr(8'h09);
        store_instr();
        repeat (3) @(posedge sys_clk);
        chk("lock_count", l + 1, m_u.n_locks);
        chk("lock_data", 16'h00c3, m_u.last_lock);
        chk("op_count", n, m_u.n_ops);
        rd(REG_CTRL, 8'h00);
    endtask

    task automatic t_program();
        load(6'd40, 16'hbeef);
        load(6'd2, 16'h0f0f);
        chk_buf(6'd40, 16'hbeef);
        chk_buf(6'd2, 16'h0f0f);
        do_op(8'h03, 16'h3800, 9'd112, 1'b1);
        do_op(8'h05, 16'h3800, 9'd112, 1'b1);
        chk_buf(6'd2, 16'hffff);
    endtask

    task automatic t_eeprom();
        load(6'd7, 16'h5a5a);
        @(posedge sys_clk);
        eeprom_write <= 1'b1;
        @(posedge sys_clk);
        eeprom_write <= 1'b0;
        chk_buf(6'd7, 16'hffff);
    endtask

    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        store_program_instr = 1'b0;
        eeprom_write = 1'b0;
        pointer = 16'h0000;
        data_register_pair = 16'h0000;
        flash_buf_idx = 6'h00;
        err_total = 0;
        compares = 0;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_codes();
        t_window();
        t_erase();
        t_lock();
        t_program();
        t_eeprom();
        stop_test();
    end
endmodule
